// *** rtl/pcc_defines.vh ***
// Constants of the converter configuration register bank.
// Behaviour
// RULE1: Sense control 10 selects output-referenced rising-slope current sensing.
// RULE2: Sense control 00 is ground-referenced falling slope, 01 output-referenced falling.
// RULE3: Ramp response bit clear waits for power good; set keeps it active throughout.
// RULE4: Alternate ramp control bit clear disables, set enables alternate ramp behaviour.
// RULE5: Bit 1 selects open-drain power good when clear, push-pull when set.
// RULE6: Bit 0 selects open-drain switch clock pin when clear, push-pull when set.
// RULE7: Minimum on-time in a ramp is (field plus one) times period over 256.
// RULE8: Minimum duty applies during ramps only while its enable bit is set.
// RULE9: Alternate ramp-down clear ramps the output down over the turn-off fall time.
// RULE10: Alternate ramp-down set holds output high impedance until undervoltage threshold.
// RULE11: Time-out bit set stops switch clock 500 ms after disable; clear keeps it.
// RULE12: Feed-forward bit clear corrects loop coefficients for input voltage; set does not.
// RULE13: Spreading clear and sequencing disabled ignores faults from other devices.
// RULE14: Spreading clear and sequencing enabled sequences down outward from failed device.
// RULE15: Spreading set makes a group fault shut this device down at once.
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define PCC_CMD_SENSE_PIN      8'hd0
`define PCC_CMD_RAMP_CLK       8'hd1

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define PCC_SENSE_PIN_RESET    16'h0000
`define PCC_RAMP_CLK_RESET     16'h0000
`define PCC_SENSE_PIN_MASK     16'hff3f
`define PCC_RAMP_CLK_MASK      16'hfbff

// ----------------------------------------------------------------------------
// Field positions of sense_and_pin_options
// ----------------------------------------------------------------------------
`define PCC_SENSE_CTRL_HI      5
`define PCC_SENSE_CTRL_LO      4
`define PCC_NLR_RAMP_BIT       3
`define PCC_ALT_RAMP_BIT       2
`define PCC_PG_PUSHPULL_BIT    1
`define PCC_SYNC_PUSHPULL_BIT  0
`define PCC_SENSE_GND_FALL     2'h0
`define PCC_SENSE_VOUT_FALL    2'h1
`define PCC_SENSE_VOUT_RISE    2'h2

// ----------------------------------------------------------------------------
// Field positions of ramp_and_clock_options
// ----------------------------------------------------------------------------
`define PCC_MIN_DUTY_HI        15
`define PCC_MIN_DUTY_LO        14
`define PCC_MIN_DUTY_EN_BIT    13
`define PCC_ALT_RAMP_DOWN_BIT  12
`define PCC_SYNC_TIMEOUT_BIT   11
`define PCC_FF_OFF_BIT         9
`define PCC_FAULT_SPREAD_BIT   8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PCC_CLK_PERIOD_NS      10
`define PCC_SYNC_TIMEOUT_MS    500
`define PCC_SYNC_TIMEOUT_CYC   ((`PCC_SYNC_TIMEOUT_MS * 1000000) / `PCC_CLK_PERIOD_NS)
`define PCC_MIN_DUTY_DIV       256

`endif

// *** rtl/pcc_sync_timeout.v ***
// Switch clock time-out timer that runs after the device is disabled.
`timescale 1ns/1ns
module pcc_sync_timeout #(
   parameter TIMEOUT_CYC = 50000000,
   parameter CNT_W       = 26
) (
   clk_sys,
   rst,
   device_enabled,
   timeout_en,
   expired
);
   input  wire             clk_sys;
   input  wire             rst;
   input  wire             device_enabled;
   input  wire             timeout_en;
   output reg              expired;

   reg [CNT_W-1:0] count_reg;

   // The count restarts on every enable, so a short disable never stops the clock.
   always @(posedge clk_sys) begin
      if (rst || device_enabled || !timeout_en) begin
         count_reg <= {CNT_W{1'b0}};
         expired   <= 1'b0;
      end else if (count_reg == TIMEOUT_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
         expired   <= 1'b1; // [RULE11]
      end else begin
         count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// *** rtl/pcc_config_bank.v ***
// Configuration register bank of a point-of-load converter controller.
`timescale 1ns/1ns
`include "pcc_defines.vh"
module pcc_config_bank #(
   parameter SYNC_TIMEOUT_CYC = `PCC_SYNC_TIMEOUT_CYC,
   parameter TIMEOUT_W        = 26
) (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        cmd_valid,
   input  wire        cmd_write,
   input  wire [7:0]  cmd_code,
   input  wire [15:0] cmd_wdata,
   output reg  [15:0] cmd_rdata,
   output reg         cmd_done,
   output reg         cmd_unsupported,
   input  wire        device_enabled,
   input  wire        ramp_up_active,
   input  wire        ramp_down_active,
   input  wire        power_good_state,
   input  wire        vout_below_uv,
   input  wire        switch_clock,
   input  wire        group_fault_received,
   input  wire        sequencing_enabled,
   output reg         sense_vout_ref,
   output reg         sense_rising_slope,
   output reg         nonlinear_response_en,
   output reg         alternate_ramp_en,
   output reg         min_duty_active,
   output reg  [8:0]  min_on_time_256ths,
   output reg         follow_turn_off_fall_time,
   output reg         output_high_impedance,
   output reg         vin_coeff_correction_en,
   output reg         shutdown_now,
   output reg         sequence_down_req,
   input  wire        power_good_output_in,
   output reg         power_good_output_out,
   output reg         power_good_output_oe_n,
   input  wire        switch_clock_pin_in,
   output reg         switch_clock_pin_out,
   output reg         switch_clock_pin_oe_n,
   output reg  [1:0]  pin_level
);

   // -------------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------------
   reg  [15:0] sense_and_pin_options_reg;
   reg  [15:0] ramp_and_clock_options_reg;
   wire        hit_sense;
   wire        hit_ramp;

   assign hit_sense = (cmd_code == `PCC_CMD_SENSE_PIN);
   assign hit_ramp  = (cmd_code == `PCC_CMD_RAMP_CLK);

   always @(posedge clk_sys) begin
      if (rst) begin
         sense_and_pin_options_reg  <= `PCC_SENSE_PIN_RESET;
         ramp_and_clock_options_reg <= `PCC_RAMP_CLK_RESET;
         cmd_rdata                  <= 16'h0000;
         cmd_done                   <= 1'b0;
         cmd_unsupported            <= 1'b0;
      end else begin
         cmd_done        <= cmd_valid;
         cmd_unsupported <= cmd_valid && !hit_sense && !hit_ramp;
         if (cmd_valid && cmd_write) begin
            if (hit_sense) begin
               sense_and_pin_options_reg <= cmd_wdata & `PCC_SENSE_PIN_MASK;
            end else if (hit_ramp) begin
               ramp_and_clock_options_reg <= cmd_wdata & `PCC_RAMP_CLK_MASK;
            end
         end
         if (cmd_valid && !cmd_write) begin
            if (hit_sense) begin
               cmd_rdata <= sense_and_pin_options_reg;
            end else if (hit_ramp) begin
               cmd_rdata <= ramp_and_clock_options_reg;
            end else begin
               cmd_rdata <= 16'h0000;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------------------
   wire [1:0] sense_ctrl;
   wire [1:0] min_duty_field;
   wire       nlr_always;
   wire       pg_push_pull;
   wire       sync_push_pull;
   wire       alt_ramp_down;
   wire       spread_faults;

   assign sense_ctrl     = sense_and_pin_options_reg[`PCC_SENSE_CTRL_HI:`PCC_SENSE_CTRL_LO];
   assign nlr_always     = sense_and_pin_options_reg[`PCC_NLR_RAMP_BIT];
   assign pg_push_pull   = sense_and_pin_options_reg[`PCC_PG_PUSHPULL_BIT];
   assign sync_push_pull = sense_and_pin_options_reg[`PCC_SYNC_PUSHPULL_BIT];
   assign min_duty_field = ramp_and_clock_options_reg[`PCC_MIN_DUTY_HI:`PCC_MIN_DUTY_LO];
   assign alt_ramp_down  = ramp_and_clock_options_reg[`PCC_ALT_RAMP_DOWN_BIT];
   assign spread_faults  = ramp_and_clock_options_reg[`PCC_FAULT_SPREAD_BIT];

   // -------------------------------------------------------------------------
   // Switch clock time-out
   // -------------------------------------------------------------------------
   wire sync_expired;

   pcc_sync_timeout #(
      .TIMEOUT_CYC (SYNC_TIMEOUT_CYC),
      .CNT_W       (TIMEOUT_W)
   ) u_sync_timeout (
      .clk_sys        (clk_sys),
      .rst            (rst),
      .device_enabled (device_enabled),
      .timeout_en     (ramp_and_clock_options_reg[`PCC_SYNC_TIMEOUT_BIT]),
      .expired        (sync_expired)
   );

   // -------------------------------------------------------------------------
   // Pin readback synchronisers
   // -------------------------------------------------------------------------
   wire [1:0] pin_raw;
   assign pin_raw = {switch_clock_pin_in, power_good_output_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
         reg s1_reg;
         reg s2_reg;
         reg s3_reg;
         // A new level is taken only once the second and third stages agree.
         always @(posedge clk_sys) begin
            if (rst) begin
               s1_reg        <= 1'b0;
               s2_reg        <= 1'b0;
               s3_reg        <= 1'b0;
               pin_level[gi] <= 1'b0;
            end else begin
               s1_reg <= pin_raw[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  pin_level[gi] <= s3_reg;
               end
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Control outputs
   // -------------------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         sense_vout_ref            <= 1'b0;
         sense_rising_slope        <= 1'b0;
         nonlinear_response_en     <= 1'b0;
         alternate_ramp_en         <= 1'b0;
         min_duty_active           <= 1'b0;
         min_on_time_256ths        <= 9'h000;
         follow_turn_off_fall_time <= 1'b0;
         output_high_impedance     <= 1'b0;
         vin_coeff_correction_en   <= 1'b1;
         shutdown_now              <= 1'b0;
         sequence_down_req         <= 1'b0;
      end else begin
         // Code 11 is undefined and falls back to ground-referenced sensing.
         sense_vout_ref     <= (sense_ctrl == `PCC_SENSE_VOUT_FALL) ||
                               (sense_ctrl == `PCC_SENSE_VOUT_RISE); // [RULE1] [RULE2]
         sense_rising_slope <= (sense_ctrl == `PCC_SENSE_VOUT_RISE); // [RULE1]
         nonlinear_response_en <= !ramp_up_active || nlr_always
                                  || power_good_state; // [RULE3]
         alternate_ramp_en  <= sense_and_pin_options_reg[`PCC_ALT_RAMP_BIT]; // [RULE4]
         min_duty_active    <= (ramp_up_active || ramp_down_active) &&
                               ramp_and_clock_options_reg[`PCC_MIN_DUTY_EN_BIT]; // [RULE8]
         if ((ramp_up_active || ramp_down_active) &&
             ramp_and_clock_options_reg[`PCC_MIN_DUTY_EN_BIT]) begin
            min_on_time_256ths <= {7'h00, min_duty_field} + 9'h001; // [RULE7]
         end else begin
            min_on_time_256ths <= 9'h000; // [RULE8]
         end
         follow_turn_off_fall_time <= ramp_down_active && !alt_ramp_down; // [RULE9]
         output_high_impedance <= ramp_down_active && alt_ramp_down
                                  && !vout_below_uv; // [RULE10]
         vin_coeff_correction_en <= !ramp_and_clock_options_reg[`PCC_FF_OFF_BIT]; // [RULE12]
         shutdown_now      <= group_fault_received && spread_faults; // [RULE15]
         // With neither spreading nor sequencing, a received fault has no effect.
         sequence_down_req <= group_fault_received && !spread_faults
                              && sequencing_enabled; // [RULE13] [RULE14]
      end
   end

   // -------------------------------------------------------------------------
   // Pin drivers
   // -------------------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         power_good_output_out  <= 1'b0;
         power_good_output_oe_n <= 1'b0;
         switch_clock_pin_out   <= 1'b0;
         switch_clock_pin_oe_n  <= 1'b1;
      end else begin
         power_good_output_out <= power_good_state;
         // Open-drain drives only the low level and releases for high.
         power_good_output_oe_n <= !pg_push_pull && power_good_state; // [RULE5]
         if (sync_expired) begin
            switch_clock_pin_out  <= 1'b0;
            switch_clock_pin_oe_n <= 1'b1; // [RULE11]
         end else begin
            switch_clock_pin_out  <= switch_clock;
            switch_clock_pin_oe_n <= !sync_push_pull && switch_clock; // [RULE6]
         end
      end
   end
endmodule

// *** verification/pcc_host_model.sv ***
// Host model that issues word commands to the configuration bank.
`timescale 1ns/1ns
module pcc_host_model (
   input  wire        clk_sys,
   input  wire        cmd_done,
   output reg         cmd_valid = 1'b0,
   output reg         cmd_write = 1'b0,
   output reg  [7:0]  cmd_code = 8'h00,
   output reg  [15:0] cmd_wdata = 16'h0000
);
   // A one-cycle request, then a bounded wait for the answer; released
   // code and data lines show the inverse so stale data cannot pass for a match.
   task xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      integer n;
      begin
         @(posedge clk_sys);
         cmd_valid <= 1'b1;
         cmd_write <= w;
         cmd_code <= c;
         cmd_wdata <= d;
         @(posedge clk_sys);
         cmd_valid <= 1'b0;
         cmd_code <= ~c;
         cmd_wdata <= ~d;
         n = 0;
         do begin
            @(posedge clk_sys);
            n = n + 1;
         end while (cmd_done !== 1'b1 && n < 4);
      end
   endtask
endmodule

// *** verification/pcc_bank_properties.sv ***
// Concurrent checks on the ports of the configuration register bank.
`timescale 1ns/1ns
`include "pcc_defines.vh"
module pcc_bank_props (
   input wire        clk_sys,
   input wire        rst,
   input wire        cmd_valid,
   input wire        cmd_write,
   input wire [7:0]  cmd_code,
   input wire [15:0] cmd_wdata,
   input wire        ramp_up_active,
   input wire        ramp_down_active,
   input wire        vout_below_uv,
   input wire        group_fault_received,
   input wire        sense_vout_ref,
   input wire        sense_rising_slope,
   input wire        min_duty_active,
   input wire [8:0]  min_on_time_256ths,
   input wire        follow_turn_off_fall_time,
   input wire        output_high_impedance,
   input wire        vin_coeff_correction_en,
   input wire        shutdown_now
);
   wire wr_sense = cmd_valid && cmd_write && cmd_code == `PCC_CMD_SENSE_PIN;
   wire wr_ramp  = cmd_valid && cmd_write && cmd_code == `PCC_CMD_RAMP_CLK;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sense_rise_a: assert property (wr_sense && cmd_wdata[5:4] == 2'h2 |-> ##2
      sense_vout_ref && sense_rising_slope) else $error("rising sense not selected");
   sense_fall_a: assert property (wr_sense && !cmd_wdata[5] |-> ##2 !sense_rising_slope
      && sense_vout_ref == $past(cmd_wdata[4], 2)) else $error("falling sense wrong");
   min_time_a: assert property (min_duty_active == (min_on_time_256ths != 9'h000)
      && min_on_time_256ths <= 9'h004) else $error("minimum on-time out of range");
   min_gate_a: assert property (min_duty_active |->
      $past(ramp_up_active || ramp_down_active)) else $error("minimum duty outside ramp");
   fall_time_a: assert property (follow_turn_off_fall_time |->
      $past(ramp_down_active) && !output_high_impedance) else $error("fall time misuse");
   hiz_cause_a: assert property (output_high_impedance |->
      $past(ramp_down_active && !vout_below_uv)) else $error("high impedance misuse");
   ff_corr_a: assert property (wr_ramp |-> ##2
      vin_coeff_correction_en == !$past(cmd_wdata[9], 2)) else $error("correction wrong");
   fault_stop_a: assert property (shutdown_now |->
      $past(group_fault_received)) else $error("shutdown without fault");
endmodule
bind pcc_config_bank pcc_bank_props pcc_bank_props_inst (.clk_sys, .rst, .cmd_valid,
   .cmd_write, .cmd_code, .cmd_wdata, .ramp_up_active, .ramp_down_active, .vout_below_uv,
   .group_fault_received, .sense_vout_ref, .sense_rising_slope, .min_duty_active,
   .min_on_time_256ths, .follow_turn_off_fall_time, .output_high_impedance,
   .vin_coeff_correction_en, .shutdown_now);

// *** verification/pcc_config_bank_tb.sv ***
// Self-checking bench of the converter configuration register bank.
`timescale 1ns/1ns
`include "pcc_defines.vh"
module pcc_config_bank_tb;
   localparam TO = 20;
   reg         clk_sys;
   reg         rst = 1'b1;
   reg  [7:0]  din = 8'h01;
   reg  [17:0] exp_q[$];
   reg  [17:0] e;
   reg  [15:0] d, m;
   reg  [7:0]  c;
   integer     err_total = 0, check_count = 0, seed = 37086, cyc = 0, i;
   wire [15:0] cmd_rdata, cmd_wdata;
   wire [8:0]  min_on_time_256ths;
   wire [7:0]  cmd_code;
   wire [1:0]  pin_level;
   wire        cmd_valid, cmd_write, cmd_done, cmd_unsupported, sense_vout_ref;
   wire        sense_rising_slope, nonlinear_response_en, alternate_ramp_en, min_duty_active;
   wire        follow_turn_off_fall_time, output_high_impedance, vin_coeff_correction_en;
   wire        shutdown_now, sequence_down_req, power_good_output_out, power_good_output_oe_n;
   wire        switch_clock_pin_out, switch_clock_pin_oe_n;
   // Both pins carry pull-ups, so a released pin reads high.
   wire        pwr_pin = power_good_output_oe_n ? 1'b1 : power_good_output_out;
   wire        clk_pin = switch_clock_pin_oe_n ? 1'b1 : switch_clock_pin_out;
   pcc_host_model pcc_host_model_inst (.clk_sys, .cmd_done, .cmd_valid, .cmd_write,
      .cmd_code, .cmd_wdata);
   pcc_config_bank #(.SYNC_TIMEOUT_CYC(TO)) pcc_config_bank_inst (.clk_sys, .rst, .cmd_valid,
      .cmd_write, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_done, .cmd_unsupported,
      .device_enabled(din[0]), .ramp_up_active(din[1]), .ramp_down_active(din[2]),
      .power_good_state(din[3]), .vout_below_uv(din[4]), .switch_clock(din[5]),
      .group_fault_received(din[6]), .sequencing_enabled(din[7]), .sense_vout_ref,
      .sense_rising_slope, .nonlinear_response_en, .alternate_ramp_en, .min_duty_active,
      .min_on_time_256ths, .follow_turn_off_fall_time, .output_high_impedance,
      .vin_coeff_correction_en, .shutdown_now, .sequence_down_req,
      .power_good_output_in(pwr_pin), .power_good_output_out, .power_good_output_oe_n,
      .switch_clock_pin_in(clk_pin), .switch_clock_pin_out, .switch_clock_pin_oe_n,
      .pin_level);
   // ------------------------------------------------------------------------
   // Shared tasks and result monitor
   // ------------------------------------------------------------------------
   task results;
      begin
         $display("checks %0d mismatches %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      begin
         check_count = check_count + 1;
         if (got !== ex) begin
            err_total = err_total + 1;
            $display("[ERR] %0s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task cmd(input logic w, input logic [7:0] cd, input logic [15:0] wd, input logic [15:0] ex);
      begin
         exp_q.push_back({cd != `PCC_CMD_SENSE_PIN && cd != `PCC_CMD_RAMP_CLK, !w, ex});
         pcc_host_model_inst.xfer(w, cd, wd);
      end
   endtask
   task put(input logic [7:0] v);
      begin
         @(posedge clk_sys);
         din <= v;
         repeat (2) @(posedge clk_sys);
         #1;
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (!rst && cmd_done === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         chk("unsupported flag", {15'h0000, e[17]}, {15'h0000, cmd_unsupported});
         if (e[16])
            chk("read word", e[15:0], cmd_rdata);
      end
   end
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         err_total = err_total + 1;
         results;
      end
   end
   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      cmd(0, `PCC_CMD_SENSE_PIN, 16'h0000, `PCC_SENSE_PIN_RESET);
      cmd(0, `PCC_CMD_RAMP_CLK, 16'h0000, `PCC_RAMP_CLK_RESET);
      cmd(0, 8'hd5, 16'h0000, 16'h0000);
      chk("coeff correction", 16'h0001, vin_coeff_correction_en);
      $display("test reset values done");
      for (i = 0; i < 8; i = i + 1) begin
         d = $random(seed);
         c = i[0] ? `PCC_CMD_RAMP_CLK : `PCC_CMD_SENSE_PIN;
         m = i[0] ? `PCC_RAMP_CLK_MASK : `PCC_SENSE_PIN_MASK;
         cmd(1, c, d, 16'h0000);
         cmd(1, 8'hd7, ~d, 16'h0000);
         cmd(0, c, 16'h0000, d & m);
      end
      $display("test readback done");
      for (i = 0; i < 4; i = i + 1) begin
         cmd(1, `PCC_CMD_SENSE_PIN, {10'h000, i[1:0], i[1], i[0], 2'b11}, 16'h0000);
         put(8'h03);
         chk("output reference", i == 1 || i == 2, sense_vout_ref);
         chk("rising slope", i == 2, sense_rising_slope);
         chk("ramp response", i[1], nonlinear_response_en);
         chk("alternate ramp", i[0], alternate_ramp_en);
         chk("power pin enable", 16'h0000, power_good_output_oe_n);
         chk("clock pin enable", 16'h0000, switch_clock_pin_oe_n);
      end
      cmd(1, `PCC_CMD_SENSE_PIN, 16'h0000, 16'h0000);
      put(8'h09);
      chk("power pin released", 16'h0001, power_good_output_oe_n);
      chk("clock pin low", 16'h0000, switch_clock_pin_oe_n);
      put(8'h29);
      chk("clock pin released", 16'h0001, switch_clock_pin_oe_n);
      chk("power pin level", 16'h0001, power_good_output_out);
      chk("clock pin level", 16'h0001, switch_clock_pin_out);
      repeat (4) @(posedge clk_sys);
      #1;
      chk("pin readback", 16'h0003, pin_level);
      $display("test sense and pins done");
      for (i = 0; i < 4; i = i + 1) begin
         cmd(1, `PCC_CMD_RAMP_CLK, {i[1:0], 1'b1, i[0], 2'b00, i[1], i[0], 8'h00}, 16'h0000);
         put(8'hc5);
         chk("minimum on-time", i[15:0] + 16'h0001, min_on_time_256ths);
         chk("minimum duty", 16'h0001, min_duty_active);
         chk("high impedance", i[0], output_high_impedance);
         chk("fall time", !i[0], follow_turn_off_fall_time);
         chk("coeff correction", !i[1], vin_coeff_correction_en);
         chk("shutdown", i[0], shutdown_now);
         chk("sequence down", !i[0], sequence_down_req);
      end
      put(8'h15);
      chk("high impedance", 16'h0000, output_high_impedance);
      chk("shutdown", 16'h0000, shutdown_now);
      cmd(1, `PCC_CMD_RAMP_CLK, 16'h0000, 16'h0000);
      put(8'h43);
      chk("minimum on-time", 16'h0000, min_on_time_256ths);
      chk("minimum duty", 16'h0000, min_duty_active);
      chk("shutdown", 16'h0000, shutdown_now);
      chk("sequence down", 16'h0000, sequence_down_req);
      $display("test ramp and faults done");
      cmd(1, `PCC_CMD_SENSE_PIN, 16'h0001, 16'h0000);
      cmd(1, `PCC_CMD_RAMP_CLK, 16'h0800, 16'h0000);
      put(8'h00);
      repeat (TO - 4) @(posedge clk_sys);
      #1;
      chk("clock before expiry", 16'h0000, switch_clock_pin_oe_n);
      repeat (8) @(posedge clk_sys);
      #1;
      chk("clock after expiry", 16'h0001, switch_clock_pin_oe_n);
      chk("clock parked low", 16'h0000, switch_clock_pin_out);
      cmd(1, `PCC_CMD_RAMP_CLK, 16'h0000, 16'h0000);
      put(8'h00);
      repeat (TO + 8) @(posedge clk_sys);
      #1;
      chk("clock kept", 16'h0000, switch_clock_pin_oe_n);
      $display("test clock time-out done");
      chk("pending answers", 16'h0000, exp_q.size() != 0);
      results;
   end
endmodule
